//--- hw/dcu_pkg.sv
package dcu_pkg;
  // ******************************
  // Sizes and timing
  // ******************************
  localparam int NCH = 2;
  localparam int FIFO_DEPTH = 64;
  localparam int OVS = 16;
  localparam logic [5:0] TICK_BIT = 6'h0F;
  localparam logic [5:0] TICK_HALF = 6'h07;
  localparam logic [5:0] TICK_STOP15 = 6'h17;
  localparam logic [5:0] TICK_STOP2 = 6'h1F;
  localparam logic [6:0] IDLE_TICKS = 7'h3F;

  // ******************************
  // Register offsets (write / read)
  // ******************************
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_LINE = 3'h1;
  localparam logic [2:0] REG_DIVLO_RDY = 3'h2;
  localparam logic [2:0] REG_DIVHI = 3'h3;
  localparam logic [2:0] REG_EFR = 3'h4;
  localparam logic [2:0] REG_TCR = 3'h5;
  localparam logic [2:0] REG_XON_LSR = 3'h6;
  localparam logic [2:0] REG_XOFF_MSR = 3'h7;

  // ******************************
  // Field positions and resets
  // ******************************
  localparam int LSR_RXAVAIL = 0;
  localparam int LSR_OVERRUN = 1;
  localparam int LSR_PARITY = 2;
  localparam int LSR_FRAME = 3;
  localparam int LSR_BREAK = 4;
  localparam int LSR_TXEMPTY = 5;
  localparam int LSR_IDLE = 6;
  localparam int LSR_UNDERRUN = 7;
  localparam int MSR_CTS = 4;
  localparam int MSR_CD = 7;
  localparam int RDY_RX = 4;
  localparam logic [7:0] LINE_RST = 8'h03;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] TCR_RST = 8'h4F;
  localparam logic [7:0] XON_RST = 8'h11;
  localparam logic [7:0] XOFF_RST = 8'h13;
  localparam logic [15:0] DIV_RST = 16'h0001;

  typedef struct packed {
    logic loop;
    logic brk;
    logic [1:0] stop;
    logic even;
    logic parEn;
    logic [1:0] wlen;
  } dcu_line_type;

  typedef struct packed {
    logic autoCts;
    logic autoRts;
    logic swFlow;
    logic xonAny;
    logic irqTx;
    logic irqLine;
    logic irqRx;
    logic pre4;
  } dcu_efr_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } dcu_state_type;
endpackage

//--- hw/dcu_baud_gen.sv
`timescale 1ns/1ps
module dcu_baud_gen (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [15:0] divisor,
  input wire logic pre4,
  output logic tick
);
  logic [1:0] pre_reg;
  logic [15:0] cnt_reg;
  logic preTick;

  assign preTick = !pre4 || (pre_reg == 2'h3);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 2'h0;
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (clkEn) begin
      pre_reg <= pre_reg + 2'h1;
      tick <= 1'b0;
      // Divisor of zero holds the generator stopped
      if (preTick && divisor != 16'h0000) begin
        if (cnt_reg >= divisor - 16'h0001) begin
          cnt_reg <= 16'h0000;
          tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule

//--- hw/dcu_fifo.sv
`timescale 1ns/1ps
module dcu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doPush;
  logic doPop;

  assign full = count_reg == (AW+1)'(DEPTH);
  assign empty = count_reg == '0;
  assign count = count_reg;
  assign dout = mem[rdPtr_reg];
  assign doPush = clkEn && push && !full;
  assign doPop = clkEn && pop && !empty;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= din;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + 1'b1;
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- hw/dcu_dual_uart.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// R01: Channel select low first, high second
// R02: Three select bits pick channel register
// R03: Carrier detect low shown in modem status
// R04: Five to eight data bits both ways
// R05: Even/odd/none parity; 1, 1.5, 2 stops
// R06: 64-deep FIFOs; interrupt at trigger level
// R07: Bit rate is clock over sixteen times divisor
// R08: Optional divide-by-four prescaler before divisor
// R09: Break, idle, framing, parity, overflow flagged
// R10: Transmit FIFO underflow reported
// R11: Control register levels halt/resume remote
// R12: One register shows all FIFO readiness
// R13: Xon/Xoff characters; optional resume on any
// R14: Auto RTS and auto CTS, separately enabled
// R15: Break sent on demand and detected
// R16: Internal loopback from transmitter to receiver
// R17: Data bit zero goes first on line
// R18: CTS gates transmit only when auto enabled
// R19: Both channels share one open-drain request
// R20: Start edge rechecked mid-bit, else discarded
// R21: Sixteen-times oversampling, bits sampled mid-bit
module dcu_dual_uart (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [2:0] regSel,
  input wire logic channelSelectLine,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic [1:0] serialIn,
  output logic [1:0] serialOut,
  input wire logic [1:0] ctsN,
  output logic [1:0] rtsN,
  input wire logic carrierDetectFirstN,
  input wire logic carrierDetectSecondN,
  output logic irqNOut,
  output logic irqNOe
);
  localparam int N = dcu_pkg::NCH;

  dcu_pkg::dcu_line_type line_reg [N];
  dcu_pkg::dcu_efr_type efr_reg [N];
  logic [7:0] tcr_reg [N];
  logic [7:0] xon_reg [N];
  logic [7:0] xoff_reg [N];
  logic [15:0] div_reg [N];
  logic [7:0] lsr_reg [N];
  logic [7:0] lsrSet [N];
  logic [7:0] txHead [N];
  logic [7:0] rxHead [N];
  logic [7:0] txWord [N];
  logic [7:0] rxWord [N];
  logic [6:0] rxCount [N];
  logic [6:0] haltLvl [N];
  logic [6:0] resumeLvl [N];
  logic [5:0] txEnd [N];
  logic [5:0] rxEnd [N];
  logic [2:0] nBits [N];
  dcu_pkg::dcu_state_type txState_reg [N];
  dcu_pkg::dcu_state_type rxState_reg [N];
  logic [5:0] txCnt_reg [N];
  logic [5:0] rxCnt_reg [N];
  logic [2:0] txBit_reg [N];
  logic [2:0] rxBit_reg [N];
  logic [7:0] txShift_reg [N];
  logic [7:0] rxShift_reg [N];
  logic [6:0] idleCnt_reg [N];
  logic [N-1:0] hit, txPush, txPop, rxPush, rxPop, lsrClr, flowGo, dataGo;
  wire [N-1:0] tick, txFull, txEmpty, rxFull, rxEmpty;
  logic [N-1:0] rxDone, rxBrk, rxFlowChar, txEff, rxIn, chanIrq;
  logic [N-1:0] txPar_reg, txLine_reg, rxPrev_reg, rxPar_reg;
  logic [N-1:0] flowHalted_reg, flowPend_reg, suspend_reg, idleArm_reg;
  logic [1:0] cdN;

  assign cdN = {carrierDetectSecondN, carrierDetectFirstN};
  assign irqNOut = 1'b0;

  function automatic logic [7:0] maskWord(input logic [7:0] d,
                                          input logic [1:0] w);
    maskWord = d & (8'hFF >> (2'h3 - w));
  endfunction

  // ******************************
  // Per-channel FIFOs and baud generators
  // ******************************
  for (genvar c = 0; c < N; c++) begin : g_chan
    dcu_fifo #(.W(8), .DEPTH(dcu_pkg::FIFO_DEPTH)) u_txFifo (
      .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .push(txPush[c]), .din(wrData), .pop(txPop[c]),
      .dout(txHead[c]), .count(), .full(txFull[c]),
      .empty(txEmpty[c])
    ); // [R06]
    dcu_fifo #(.W(8), .DEPTH(dcu_pkg::FIFO_DEPTH)) u_rxFifo (
      .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .push(rxPush[c]), .din(rxWord[c]), .pop(rxPop[c]),
      .dout(rxHead[c]), .count(rxCount[c]), .full(rxFull[c]),
      .empty(rxEmpty[c])
    ); // [R06]
    dcu_baud_gen u_baud (
      .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .divisor(div_reg[c]), .pre4(efr_reg[c].pre4),
      .tick(tick[c])
    ); // [R07] [R08]
  end

  // ******************************
  // Decode and per-channel combinational terms
  // ******************************
  always_comb begin
    for (int c = 0; c < N; c++) begin
      hit[c] = channelSelectLine == 1'(c); // [R01]
      txPush[c] = clkEn && wrStb && hit[c] &&
                  regSel == dcu_pkg::REG_DATA && !txFull[c]; // [R02]
      rxPop[c] = clkEn && rdStb && hit[c] &&
                 regSel == dcu_pkg::REG_DATA && !rxEmpty[c];
      lsrClr[c] = clkEn && rdStb && hit[c] &&
                  regSel == dcu_pkg::REG_XON_LSR;
      haltLvl[c] = {1'b0, tcr_reg[c][3:0], 2'b00}; // [R11]
      resumeLvl[c] = {1'b0, tcr_reg[c][7:4], 2'b00}; // [R11]
      nBits[c] = 3'h4 + {1'b0, line_reg[c].wlen}; // [R04]
      txEff[c] = line_reg[c].brk ? 1'b0 : txLine_reg[c]; // [R15]
      rxIn[c] = line_reg[c].loop ? txEff[c] : serialIn[c]; // [R16]
      flowGo[c] = tick[c] && txState_reg[c] == dcu_pkg::ST_IDLE &&
                  efr_reg[c].swFlow && flowPend_reg[c];
      dataGo[c] = tick[c] && txState_reg[c] == dcu_pkg::ST_IDLE &&
                  !flowGo[c] && !txEmpty[c] &&
                  !(efr_reg[c].swFlow && suspend_reg[c]) && // [R13]
                  !(efr_reg[c].autoCts && ctsN[c]); // [R14] [R18]
      txPop[c] = clkEn && dataGo[c];
      txWord[c] = !flowGo[c] ? txHead[c] :
                  (flowHalted_reg[c] ? xoff_reg[c] : xon_reg[c]);
      if (txState_reg[c] != dcu_pkg::ST_STOP) begin
        txEnd[c] = dcu_pkg::TICK_BIT;
      end else if (line_reg[c].stop == 2'h0) begin
        txEnd[c] = dcu_pkg::TICK_BIT;
      end else if (line_reg[c].stop == 2'h1) begin
        txEnd[c] = dcu_pkg::TICK_STOP15; // [R05]
      end else begin
        txEnd[c] = dcu_pkg::TICK_STOP2; // [R05]
      end
      rxEnd[c] = rxState_reg[c] == dcu_pkg::ST_START ?
                 dcu_pkg::TICK_HALF : dcu_pkg::TICK_BIT; // [R21]
      rxWord[c] = rxShift_reg[c] >> (2'h3 - line_reg[c].wlen);
      rxDone[c] = clkEn && tick[c] && rxState_reg[c] == dcu_pkg::ST_STOP
                  && rxCnt_reg[c] == rxEnd[c];
      rxBrk[c] = rxWord[c] == 8'h00 && !rxIn[c] &&
                 (!line_reg[c].parEn || !rxPar_reg[c]); // [R15]
      rxFlowChar[c] = efr_reg[c].swFlow &&
                      (rxWord[c] == xon_reg[c] || rxWord[c] == xoff_reg[c]);
      rxPush[c] = rxDone[c] && !rxBrk[c] && !rxFlowChar[c];
      lsrSet[c] = 8'h00;
      lsrSet[c][dcu_pkg::LSR_OVERRUN] = rxPush[c] && rxFull[c]; // [R09]
      lsrSet[c][dcu_pkg::LSR_PARITY] = rxDone[c] && !rxBrk[c] &&
        line_reg[c].parEn &&
        (rxPar_reg[c] != (line_reg[c].even ? ^rxWord[c] : ~^rxWord[c]));
      lsrSet[c][dcu_pkg::LSR_FRAME] = rxDone[c] && !rxBrk[c] && !rxIn[c];
      lsrSet[c][dcu_pkg::LSR_BREAK] = rxDone[c] && rxBrk[c]; // [R09]
      lsrSet[c][dcu_pkg::LSR_IDLE] = clkEn && tick[c] && idleArm_reg[c]
        && idleCnt_reg[c] == dcu_pkg::IDLE_TICKS; // [R09]
      lsrSet[c][dcu_pkg::LSR_UNDERRUN] = clkEn && tick[c] &&
        txState_reg[c] == dcu_pkg::ST_STOP &&
        txCnt_reg[c] == txEnd[c] && txEmpty[c]; // [R10]
      chanIrq[c] = (efr_reg[c].irqRx && rxCount[c] >= resumeLvl[c]) ||
                   (efr_reg[c].irqLine && |lsr_reg[c]) ||
                   (efr_reg[c].irqTx && txEmpty[c]); // [R06]
    end
  end

  // ******************************
  // Configuration registers
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        line_reg[c] <= dcu_pkg::LINE_RST;
        efr_reg[c] <= dcu_pkg::EFR_RST;
        tcr_reg[c] <= dcu_pkg::TCR_RST;
        xon_reg[c] <= dcu_pkg::XON_RST;
        xoff_reg[c] <= dcu_pkg::XOFF_RST;
        div_reg[c] <= dcu_pkg::DIV_RST;
      end
    end else if (clkEn && wrStb) begin
      if (regSel == dcu_pkg::REG_LINE) begin
        line_reg[channelSelectLine] <= wrData; // [R01] [R02]
      end else if (regSel == dcu_pkg::REG_DIVLO_RDY) begin
        div_reg[channelSelectLine][7:0] <= wrData; // [R07]
      end else if (regSel == dcu_pkg::REG_DIVHI) begin
        div_reg[channelSelectLine][15:8] <= wrData; // [R07]
      end else if (regSel == dcu_pkg::REG_EFR) begin
        efr_reg[channelSelectLine] <= wrData;
      end else if (regSel == dcu_pkg::REG_TCR) begin
        tcr_reg[channelSelectLine] <= wrData; // [R11]
      end else if (regSel == dcu_pkg::REG_XON_LSR) begin
        xon_reg[channelSelectLine] <= wrData; // [R13]
      end else if (regSel == dcu_pkg::REG_XOFF_MSR) begin
        xoff_reg[channelSelectLine] <= wrData; // [R13]
      end
    end
  end

  // ******************************
  // Transmitter
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        txState_reg[c] <= dcu_pkg::ST_IDLE;
        txCnt_reg[c] <= 6'h00;
        txBit_reg[c] <= 3'h0;
        txShift_reg[c] <= 8'h00;
        txPar_reg[c] <= 1'b0;
        txLine_reg[c] <= 1'b1;
      end
    end else if (clkEn) begin
      for (int c = 0; c < N; c++) begin
        if (tick[c] && txState_reg[c] == dcu_pkg::ST_IDLE) begin
          if (flowGo[c] || dataGo[c]) begin
            txShift_reg[c] <= maskWord(txWord[c], line_reg[c].wlen);
            txPar_reg[c] <= line_reg[c].even ?
              ^maskWord(txWord[c], line_reg[c].wlen) :
              ~^maskWord(txWord[c], line_reg[c].wlen); // [R05]
            txLine_reg[c] <= 1'b0;
            txCnt_reg[c] <= 6'h00;
            txState_reg[c] <= dcu_pkg::ST_START;
          end
        end else if (tick[c] && txCnt_reg[c] != txEnd[c]) begin
          txCnt_reg[c] <= txCnt_reg[c] + 6'h01;
        end else if (tick[c]) begin
          txCnt_reg[c] <= 6'h00;
          case (txState_reg[c])
            dcu_pkg::ST_START: begin
              txLine_reg[c] <= txShift_reg[c][0]; // [R17]
              txShift_reg[c] <= txShift_reg[c] >> 1;
              txBit_reg[c] <= 3'h0;
              txState_reg[c] <= dcu_pkg::ST_DATA;
            end
            dcu_pkg::ST_DATA: begin
              if (txBit_reg[c] == nBits[c]) begin // [R04]
                txLine_reg[c] <= line_reg[c].parEn ? txPar_reg[c] : 1'b1;
                txState_reg[c] <= line_reg[c].parEn ?
                  dcu_pkg::ST_PAR : dcu_pkg::ST_STOP;
              end else begin
                txBit_reg[c] <= txBit_reg[c] + 3'h1;
                txLine_reg[c] <= txShift_reg[c][0]; // [R17]
                txShift_reg[c] <= txShift_reg[c] >> 1;
              end
            end
            dcu_pkg::ST_PAR: begin
              txLine_reg[c] <= 1'b1;
              txState_reg[c] <= dcu_pkg::ST_STOP;
            end
            default: begin
              txState_reg[c] <= dcu_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ******************************
  // Receiver
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        rxState_reg[c] <= dcu_pkg::ST_IDLE;
        rxCnt_reg[c] <= 6'h00;
        rxBit_reg[c] <= 3'h0;
        rxShift_reg[c] <= 8'h00;
        rxPar_reg[c] <= 1'b0;
        rxPrev_reg[c] <= 1'b1;
      end
    end else if (clkEn) begin
      for (int c = 0; c < N; c++) begin
        if (tick[c]) begin
          rxPrev_reg[c] <= rxIn[c];
        end
        // A line held low after a break never re-arms until it rises
        if (tick[c] && rxState_reg[c] == dcu_pkg::ST_IDLE) begin
          if (rxPrev_reg[c] && !rxIn[c]) begin
            rxCnt_reg[c] <= 6'h00;
            rxState_reg[c] <= dcu_pkg::ST_START;
          end
        end else if (tick[c] && rxCnt_reg[c] != rxEnd[c]) begin
          rxCnt_reg[c] <= rxCnt_reg[c] + 6'h01;
        end else if (tick[c]) begin
          rxCnt_reg[c] <= 6'h00;
          case (rxState_reg[c])
            dcu_pkg::ST_START: begin
              rxBit_reg[c] <= 3'h0;
              rxState_reg[c] <= rxIn[c] ?
                dcu_pkg::ST_IDLE : dcu_pkg::ST_DATA; // [R20]
            end
            dcu_pkg::ST_DATA: begin
              rxShift_reg[c] <= {rxIn[c], rxShift_reg[c][7:1]}; // [R17]
              if (rxBit_reg[c] == nBits[c]) begin
                rxState_reg[c] <= line_reg[c].parEn ?
                  dcu_pkg::ST_PAR : dcu_pkg::ST_STOP;
              end else begin
                rxBit_reg[c] <= rxBit_reg[c] + 3'h1; // [R21]
              end
            end
            dcu_pkg::ST_PAR: begin
              rxPar_reg[c] <= rxIn[c]; // [R05]
              rxState_reg[c] <= dcu_pkg::ST_STOP;
            end
            default: begin
              rxState_reg[c] <= dcu_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ******************************
  // Flow control, status and pins
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        flowHalted_reg[c] <= 1'b0;
        flowPend_reg[c] <= 1'b0;
        suspend_reg[c] <= 1'b0;
        idleArm_reg[c] <= 1'b0;
        idleCnt_reg[c] <= 7'h00;
        lsr_reg[c] <= 8'h00;
      end
      serialOut <= 2'h3;
      rtsN <= 2'h0;
      irqNOe <= 1'b0;
    end else if (clkEn) begin
      for (int c = 0; c < N; c++) begin
        if (!flowHalted_reg[c] && rxCount[c] >= haltLvl[c]) begin
          flowHalted_reg[c] <= 1'b1; // [R11]
          flowPend_reg[c] <= efr_reg[c].swFlow;
        end else if (flowHalted_reg[c] && rxCount[c] <= resumeLvl[c]) begin
          flowHalted_reg[c] <= 1'b0; // [R11]
          flowPend_reg[c] <= efr_reg[c].swFlow;
        end else if (flowGo[c] || !efr_reg[c].swFlow) begin
          flowPend_reg[c] <= 1'b0;
        end
        if (!efr_reg[c].swFlow) begin
          suspend_reg[c] <= 1'b0;
        end else if (rxDone[c] && !rxBrk[c]) begin
          if (rxWord[c] == xoff_reg[c]) begin
            suspend_reg[c] <= 1'b1; // [R13]
          end else if (rxWord[c] == xon_reg[c] || efr_reg[c].xonAny) begin
            suspend_reg[c] <= 1'b0; // [R13]
          end
        end
        if (rxDone[c]) begin
          idleArm_reg[c] <= 1'b1;
        end else if (lsrSet[c][dcu_pkg::LSR_IDLE]) begin
          idleArm_reg[c] <= 1'b0;
        end
        if (rxState_reg[c] != dcu_pkg::ST_IDLE || !rxIn[c]) begin
          idleCnt_reg[c] <= 7'h00;
        end else if (tick[c] && idleArm_reg[c]) begin
          idleCnt_reg[c] <= idleCnt_reg[c] + 7'h01;
        end
        // Set wins over a read in the same cycle
        lsr_reg[c] <= (lsr_reg[c] & {8{!lsrClr[c]}}) | lsrSet[c]; // [R09]
        serialOut[c] <= line_reg[c].loop ? 1'b1 : txEff[c]; // [R15] [R16]
        rtsN[c] <= efr_reg[c].autoRts && flowHalted_reg[c]; // [R14]
      end
      irqNOe <= |chanIrq; // [R19]
    end
  end

  // ******************************
  // Host read port
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (clkEn) begin
      rdData <= 8'h00;
      if (!rdStb) begin
        rdData <= 8'h00;
      end else if (regSel == dcu_pkg::REG_DATA) begin
        rdData <= rxEmpty[channelSelectLine] ?
                  8'h00 : rxHead[channelSelectLine];
      end else if (regSel == dcu_pkg::REG_LINE) begin
        rdData <= line_reg[channelSelectLine];
      end else if (regSel == dcu_pkg::REG_DIVLO_RDY) begin
        rdData[N-1:0] <= ~txFull; // [R12]
        rdData[dcu_pkg::RDY_RX +: N] <= ~rxEmpty; // [R12]
      end else if (regSel == dcu_pkg::REG_DIVHI) begin
        rdData <= div_reg[channelSelectLine][15:8];
      end else if (regSel == dcu_pkg::REG_EFR) begin
        rdData <= efr_reg[channelSelectLine];
      end else if (regSel == dcu_pkg::REG_TCR) begin
        rdData <= tcr_reg[channelSelectLine];
      end else if (regSel == dcu_pkg::REG_XON_LSR) begin
        rdData <= lsr_reg[channelSelectLine];
        rdData[dcu_pkg::LSR_RXAVAIL] <= !rxEmpty[channelSelectLine];
        rdData[dcu_pkg::LSR_TXEMPTY] <= txEmpty[channelSelectLine];
      end else begin
        rdData[dcu_pkg::MSR_CD] <= !cdN[channelSelectLine]; // [R03]
        rdData[dcu_pkg::MSR_CTS] <= !ctsN[channelSelectLine]; // [R18]
      end
    end
  end
endmodule

//--- bench/dcu_dual_uart_monitor.sv
`timescale 1ns/1ps
module dcu_dual_uart_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [2:0] regSel,
  input wire logic channelSelectLine,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdData,
  input wire logic [1:0] serialOut,
  input wire logic [1:0] ctsN,
  input wire logic carrierDetectFirstN,
  input wire logic carrierDetectSecondN,
  input wire logic irqNOut
);
  // ********
  // Checks
  // ********
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n || !clkEn);
  rd_idle_a: assert property (
    !$past(rdStb) |-> rdData == 8'h00) else $error("stray read data");
  cd_view_a: assert property (
    $past(rdStb && regSel == 3'h7) |-> rdData[7] ==
    !$past(channelSelectLine ? carrierDetectSecondN : carrierDetectFirstN)
  ) else $error("carrier status wrong");
  cts_view_a: assert property (
    $past(rdStb && regSel == 3'h7) |->
    rdData[4] == !$past(ctsN[channelSelectLine])
  ) else $error("clear status wrong");
  rdy_spare_a: assert property (
    $past(rdStb && regSel == 3'h2) |->
    rdData[3:2] == 2'h0 && rdData[7:6] == 2'h0
  ) else $error("ready spare bits set");
  divhi_back_a: assert property (
    wrStb && regSel == 3'h3 ##1 rdStb && regSel == 3'h3 &&
    $stable(channelSelectLine) |=> rdData == $past(wrData, 2)
  ) else $error("divisor readback wrong");
  low_run0_a: assert property (
    $fell(serialOut[0]) |-> (!serialOut[0]) [*8] ##1 (!serialOut[0]) [*7]
  ) else $error("short bit ch0");
  low_run1_a: assert property (
    $fell(serialOut[1]) |-> (!serialOut[1]) [*8] ##1 (!serialOut[1]) [*7]
  ) else $error("short bit ch1");
  irq_level_a: assert property (
    irqNOut == 1'b0) else $error("request value not low");
endmodule
bind dcu_dual_uart dcu_dual_uart_monitor i_mon (.mclk, .rst_n, .clkEn,
  .regSel, .channelSelectLine, .wrData, .wrStb, .rdStb, .rdData,
  .serialOut, .ctsN, .carrierDetectFirstN, .carrierDetectSecondN, .irqNOut);

//--- bench/dcu_serial_peer.sv
`timescale 1ns/1ps
module dcu_serial_peer (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  int bitLen = 16;
  int gotCnt = 0;
  logic [8:0] got = 9'h000;
  initial rxLine = 1'b1;
  // ********
  // Decoder
  // ********
  // Nine bits kept so parity or stop shows in bit 8
  always begin
    @(negedge txLine);
    repeat (bitLen / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bitLen) @(posedge mclk);
      got[i] = txLine;
    end
    gotCnt++;
  end
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxLine <= f[i];
      repeat (bitLen) @(posedge mclk);
    end
    rxLine <= 1'b1;
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regSel = 3'h0;
  logic chSel = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [1:0] ctsN = 2'h0;
  logic [7:0] q;
  wire [7:0] rdData;
  wire [1:0] rxd;
  wire [1:0] txd;
  int miscompares = 0;
  int samplesChecked = 0;
  always #50 mclk = ~mclk;
  dcu_dual_uart i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1),
    .regSel(regSel), .channelSelectLine(chSel), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .serialIn(rxd),
    .serialOut(txd), .ctsN(ctsN), .rtsN(), .carrierDetectFirstN(1'b0),
    .carrierDetectSecondN(1'b1), .irqNOut(), .irqNOe());
  dcu_serial_peer p0 (.mclk(mclk), .txLine(txd[0]), .rxLine(rxd[0]));
  dcu_serial_peer p1 (.mclk(mclk), .txLine(txd[1]), .rxLine(rxd[1]));
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    samplesChecked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, c, input logic [2:0] a,
    input logic [7:0] d);
    @(posedge mclk);
    {wrStb, rdStb, chSel, regSel, wrData} <= {w, !w, c, a, d};
    @(posedge mclk);
    {wrStb, rdStb} <= 2'h0;
    #1 q = rdData;
  endtask
  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, c, a, d);
  endtask
  task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, c, a, 8'h00);
    chk({1'b0, q}, {1'b0, e});
  endtask
  task automatic txw(input logic c, input logic [7:0] d, input logic [8:0] e);
    int n;
    n = c ? p1.gotCnt : p0.gotCnt;
    wr(c, 3'h0, d);
    for (int k = 0; k < 3000 && n == (c ? p1.gotCnt : p0.gotCnt); k++)
      @(posedge mclk);
    chk(c ? p1.got : p0.got, e);
    repeat (70) @(posedge mclk);
  endtask
  task t_regs;
    for (int c = 0; c < 2; c++) begin
      rd(c[0], 3'h1, 8'h03);
      rd(c[0], 3'h4, 8'h00);
      rd(c[0], 3'h5, 8'h4F);
      rd(c[0], 3'h2, 8'h03);
      rd(c[0], 3'h6, 8'h20);
    end
    rd(1'b0, 3'h7, 8'h90);
    rd(1'b1, 3'h7, 8'h10);
    @(posedge mclk);
    {wrStb, chSel, regSel, wrData} <= {1'b1, 1'b1, 3'h3, 8'h5A};
    @(posedge mclk);
    {wrStb, rdStb} <= 2'h1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 chk({1'b0, rdData}, 9'h05A);
    wr(1'b1, 3'h3, 8'h00);
    $display("regs done");
  endtask
  task t_tx;
    txw(1'b0, 8'hA5, 9'h1A5);
    txw(1'b1, 8'h3C, 9'h13C);
    wr(1'b0, 3'h1, 8'h00);
    txw(1'b0, 8'h15, 9'h1F5);
    wr(1'b0, 3'h1, 8'h0F);
    txw(1'b0, 8'h03, 9'h003);
    wr(1'b0, 3'h1, 8'h07);
    txw(1'b0, 8'h03, 9'h103);
    wr(1'b0, 3'h1, 8'h03);
    wr(1'b0, 3'h2, 8'h02);
    p0.bitLen = 32;
    txw(1'b0, 8'h81, 9'h181);
    wr(1'b0, 3'h2, 8'h01);
    wr(1'b0, 3'h4, 8'h01);
    p0.bitLen = 64;
    txw(1'b0, 8'h42, 9'h142);
    wr(1'b0, 3'h4, 8'h00);
    p0.bitLen = 16;
    $display("tx done");
  endtask
  task t_rx;
    rd(1'b1, 3'h6, 8'hA0);
    p1.send({3'h7, 8'h5A, 1'b0}, 10);
    repeat (16) @(posedge mclk);
    rd(1'b1, 3'h2, 8'h23);
    rd(1'b1, 3'h0, 8'h5A);
    rd(1'b1, 3'h0, 8'h00);
    p1.send({3'h0, 8'h11, 1'b0}, 10);
    repeat (16) @(posedge mclk);
    rd(1'b1, 3'h6, 8'h29);
    rd(1'b1, 3'h0, 8'h11);
    // Low for a quarter bit only
    p0.bitLen = 4;
    p0.send(12'h000, 1);
    p0.bitLen = 16;
    repeat (200) @(posedge mclk);
    rd(1'b0, 3'h2, 8'h03);
    $display("rx done");
  endtask
  task automatic t_loop;
    int n;
    n = 0;
    wr(1'b0, 3'h1, 8'h83);
    wr(1'b0, 3'h0, 8'h96);
    repeat (250) @(posedge mclk) n += txd[0];
    chk(n[8:0], 9'h0FA);
    rd(1'b0, 3'h0, 8'h96);
    acc(1'b0, 1'b0, 3'h6, 8'h00);
    wr(1'b0, 3'h1, 8'hC3);
    repeat (400) @(posedge mclk);
    wr(1'b0, 3'h1, 8'h83);
    acc(1'b0, 1'b0, 3'h6, 8'h00);
    chk({8'h00, q[4]}, 9'h001);
    wr(1'b0, 3'h1, 8'h43);
    repeat (50) @(posedge mclk);
    chk({8'h00, txd[0]}, 9'h000);
    wr(1'b0, 3'h1, 8'h03);
    repeat (200) @(posedge mclk);
    $display("loop done");
  endtask
  task t_cts;
    wr(1'b0, 3'h4, 8'h80);
    @(posedge mclk);
    ctsN[0] <= 1'b1;
    fork
      txw(1'b0, 8'h5C, 9'h15C);
      begin
        repeat (300) @(posedge mclk);
        chk({8'h00, txd[0]}, 9'h001);
        ctsN[0] <= 1'b0;
      end
    join
    @(posedge mclk);
    ctsN[0] <= 1'b1;
    for (int k = 0; k < 64; k++) wr(1'b0, 3'h0, k[7:0]);
    rd(1'b0, 3'h2, 8'h02);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(1'b0, 3'h2, 8'h03);
    $display("cts done");
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_loop;
    t_cts;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish;
  end
endmodule
